//--- core/rpm_pkg.sv
/*
  Package for the root port packet mailbox: register map, control and status
  field positions, FIFO sizing and command encodings shared by both ends.
  Assumes a single 20 MHz clock and a synchronous active-high reset.
*/
package rpm_pkg;
  localparam int RPM_AW = 16;
  localparam int RPM_DW = 32;
  localparam logic [RPM_AW-1:0] RPM_TX_DWORD_OFF = 16'h2000;
  localparam logic [RPM_AW-1:0] RPM_TX_CTRL_OFF = 16'h2004;
  localparam logic [RPM_AW-1:0] RPM_RX_DWORD_OFF = 16'h2008;
  localparam logic [RPM_AW-1:0] RPM_RX_STATUS_OFF = 16'h200c;
  localparam int RPM_CTL_FIRST = 0;
  localparam int RPM_CTL_LAST = 1;
  localparam int RPM_CTL_POSTED = 2;
  localparam int RPM_ST_FIRST = 0;
  localparam int RPM_ST_LAST = 1;
  localparam logic [2:0] RPM_CMD_FIRST_NP = 3'h1;
  localparam logic [2:0] RPM_CMD_MIDDLE = 3'h0;
  localparam logic [2:0] RPM_CMD_LAST = 3'h2;
  localparam int RPM_FIFO_DEPTH = 8;
  localparam int RPM_PTR_W = 3;
  localparam logic [RPM_DW-1:0] RPM_ZERO = 32'h0000_0000;
  localparam logic [RPM_DW-1:0] RPM_DUMMY = 32'h0000_0000;
  // Host-side controller registers
  localparam logic [3:0] RPM_H_CMD_OFF = 4'h0;
  localparam logic [3:0] RPM_H_DATA_OFF = 4'h1;
  localparam logic [3:0] RPM_H_STAT_OFF = 4'h2;
  localparam logic [3:0] RPM_H_RXD_OFF = 4'h3;
  localparam int RPM_HCMD_SEND = 0;
  localparam int RPM_HCMD_FIRST = 1;
  localparam int RPM_HCMD_LAST = 2;
  localparam int RPM_HCMD_POSTED = 3;
  localparam int RPM_HCMD_RECV = 4;
  localparam int RPM_HCMD_PAD = 5;
endpackage : rpm_pkg

//--- core/rpm_if.sv
/*
  Register port between the application controller and the mailbox device.
  Assumes both ends share clock_in; read data is valid the cycle after read.
*/
`timescale 1ns/1ns
interface rpm_if;
  import rpm_pkg::*;
  logic [RPM_AW-1:0] addr;
  logic [RPM_DW-1:0] wdata;
  logic write;
  logic read;
  logic [RPM_DW-1:0] rdata;
  logic rvalid;
  logic wait_req;
  modport dev (input addr, wdata, write, read, output rdata, rvalid, wait_req);
  modport app (output addr, wdata, write, read, input rdata, rvalid, wait_req);
endinterface : rpm_if

//--- core/rpm_device.sv
/*
  Mailbox device end: assembles pushed dwords into packets, releases whole
  packets downstream, and presents returned completions dword by dword.
  Assumes the application obeys the push and poll sequences.
*/
// Notes on behaviour
// - Write 0x2000 holds next transmit dword
// - Control bit 2 selects posted request
// - Control bit 1 last, bit 0 first
// - Control 001 pushes first non-posted dword
// - Data then control; 000 middle, 010 last
// - Closed packet is transmitted downstream whole
// - Completions queued in receive FIFO
// - Read 0x2008 returns one receive dword
// - Status 0x200c bit 0 first dword present
// - Status bit 1 marks final dword next
// - Status 0 means middle, 2 final
// - Application polls bit 0 then reads
// - Application checks last flag per read
// - One non-posted request outstanding at most; np_out_q only reports it, no send is blocked
// - Non-posted tags lie in 16..31
// - Check link active before configuration
// - Same write sequence for any datapath width
// - Control register port is 32 bits
// - Odd header packets padded with zero dword
`timescale 1ns/1ns
module rpm_device
  import rpm_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Register port
  rpm_if.dev bus,
  // Downstream transmit stream
  output logic [RPM_DW-1:0] tx_data_out,
  output logic tx_valid_out,
  output logic tx_first_out,
  output logic tx_last_out,
  output logic tx_posted_out,
  input wire logic tx_ready_in,
  // Upstream completion stream
  input wire logic [RPM_DW-1:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_first_in,
  input wire logic rx_last_in,
  output logic rx_ready_out
);
  localparam int FW = RPM_DW + 3;
  logic [RPM_DW-1:0] tx_dword_q;
  logic [FW-1:0] txf_q [RPM_FIFO_DEPTH];
  logic [RPM_PTR_W:0] txw_q;
  logic [RPM_PTR_W:0] txr_q;
  logic [RPM_PTR_W:0] txc_q;
  logic [RPM_DW+1:0] rxf_q [RPM_FIFO_DEPTH];
  logic [RPM_PTR_W:0] rxw_q;
  logic [RPM_PTR_W:0] rxr_q;
  logic [RPM_DW-1:0] rdata_q;
  logic rvalid_q;
  logic status_read_q;
  logic tx_full;
  logic tx_push;
  logic tx_pop;
  logic rx_full;
  logic rx_empty;
  logic rx_push;
  logic rx_pop;
  logic rd_dword;
  logic rd_status;
  logic [1:0] rx_flags;
  logic [FW-1:0] tx_head;
  logic [RPM_DW+1:0] rx_head;

  function automatic logic hit(input logic [RPM_AW-1:0] a, input logic [RPM_AW-1:0] off);
    hit = (a == off);
  endfunction : hit

  // Head decode for status; empty reads as no flags at all
  function automatic logic [1:0] head_flags(input logic empty, input logic [RPM_DW+1:0] head);
    logic [1:0] f;
    f = 2'h0;
    if (!empty) begin
      f[RPM_ST_FIRST] = head[RPM_DW];
      f[RPM_ST_LAST] = head[RPM_DW+1] && !head[RPM_DW];
    end
    head_flags = f;
  endfunction : head_flags

  assign tx_full = (txw_q - txr_q) == (RPM_PTR_W+1)'(RPM_FIFO_DEPTH);
  assign tx_push = bus.write && hit(bus.addr, RPM_TX_CTRL_OFF) && !tx_full;
  assign tx_head = txf_q[txr_q[RPM_PTR_W-1:0]];
  // A packet leaves only after its last dword is queued, so it goes out unbroken
  assign tx_pop = (txc_q != 0) && (!tx_valid_out || tx_ready_in);
  assign rx_full = (rxw_q - rxr_q) == (RPM_PTR_W+1)'(RPM_FIFO_DEPTH);
  assign rx_empty = rxw_q == rxr_q;
  assign rx_push = rx_valid_in && rx_ready_out;
  assign rd_dword = bus.read && hit(bus.addr, RPM_RX_DWORD_OFF);
  assign rx_pop = rd_dword && !rx_empty;
  assign rx_head = rxf_q[rxr_q[RPM_PTR_W-1:0]];
  assign rd_status = bus.read && hit(bus.addr, RPM_RX_STATUS_OFF);
  assign rx_flags = head_flags(rx_empty, rx_head);
  assign bus.wait_req = tx_full && bus.write && hit(bus.addr, RPM_TX_CTRL_OFF);
  assign bus.rdata = rdata_q;
  assign bus.rvalid = rvalid_q;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_dword_q <= RPM_ZERO;
    end else if (bus.write && hit(bus.addr, RPM_TX_DWORD_OFF)) begin
      tx_dword_q <= bus.wdata;
    end
  end

  always_ff @(posedge clock_in) begin
    if (tx_push) begin
      txf_q[txw_q[RPM_PTR_W-1:0]] <= {bus.wdata[RPM_CTL_POSTED], bus.wdata[RPM_CTL_LAST],
                                      bus.wdata[RPM_CTL_FIRST], tx_dword_q};
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      txw_q <= '0;
      txr_q <= '0;
      txc_q <= '0;
    end else begin
      if (tx_push) begin
        txw_q <= txw_q + 1'b1;
      end
      if (tx_pop) begin
        txr_q <= txr_q + 1'b1;
      end
      // Count of closed packets waiting
      txc_q <= txc_q + (RPM_PTR_W+1)'(tx_push && bus.wdata[RPM_CTL_LAST])
                     - (RPM_PTR_W+1)'(tx_pop && tx_head[RPM_DW+1]);
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_valid_out <= 1'b0;
      tx_data_out <= RPM_ZERO;
      tx_first_out <= 1'b0;
      tx_last_out <= 1'b0;
      tx_posted_out <= 1'b0;
    end else if (tx_pop) begin
      tx_valid_out <= 1'b1;
      tx_data_out <= tx_head[RPM_DW-1:0];
      tx_first_out <= tx_head[RPM_DW];
      tx_last_out <= tx_head[RPM_DW+1];
      tx_posted_out <= tx_head[RPM_DW+2];
    end else if (tx_ready_in) begin
      tx_valid_out <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rx_push) begin
      rxf_q[rxw_q[RPM_PTR_W-1:0]] <= {rx_last_in, rx_first_in, rx_data_in};
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rxw_q <= '0;
      rxr_q <= '0;
      rx_ready_out <= 1'b0;
    end else begin
      if (rx_push) begin
        rxw_q <= rxw_q + 1'b1;
      end
      if (rx_pop) begin
        rxr_q <= rxr_q + 1'b1;
      end
      // Registered ready keeps two slots spare, one for the push already in flight
      rx_ready_out <= (rxw_q - rxr_q) < (RPM_PTR_W+1)'(RPM_FIFO_DEPTH - 2) && !rx_full;
    end
  end

  // Read-clear: a status read that shows a flag hides it until the next pop;
  // the pop re-arms it at once, so a new head is never hidden (the pop wins)
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      status_read_q <= 1'b0;
    end else if (rx_pop) begin
      status_read_q <= 1'b0;
    end else if (rd_status && rx_flags != 2'h0) begin
      status_read_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rdata_q <= RPM_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.read;
      if (rd_dword) begin
        rdata_q <= rx_empty ? RPM_ZERO : rx_head[RPM_DW-1:0];
      end else if (rd_status) begin
        // Flags come from the head itself, so a read just after a pop is current
        rdata_q <= {30'h0, status_read_q ? 2'h0 : rx_flags};
      end else begin
        rdata_q <= RPM_ZERO;
      end
    end
  end
endmodule : rpm_device

//--- core/rpm_app.sv
/*
  Application end: a small controller that turns host register commands into
  the mailbox push and poll sequences. Assumes the device on the rpm_if port.
*/
`timescale 1ns/1ns
module rpm_app
  import rpm_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Host register port
  input wire logic [3:0] h_addr_in,
  input wire logic [RPM_DW-1:0] h_wdata_in,
  input wire logic h_write_in,
  input wire logic h_read_in,
  output logic [RPM_DW-1:0] h_rdata_out,
  // Mailbox port
  rpm_if.app bus
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_WDATA = 6'h02, ST_WCTRL = 6'h04,
    ST_POLL = 6'h08, ST_RDATA = 6'h10, ST_WAIT = 6'h20
  } rpm_state_e;
  rpm_state_e state_q;
  logic [RPM_DW-1:0] data_q, rxd_q;
  logic [5:0] cmd_q;
  logic busy_q, rx_last_q, rx_done_q, np_out_q;
  logic [RPM_AW-1:0] addr_q;
  logic [RPM_DW-1:0] wdata_q;
  logic write_q, read_q, pad_q, rd_status_q;

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.write = write_q;
  assign bus.read = read_q;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      write_q <= 1'b0;
      read_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= RPM_ZERO;
      busy_q <= 1'b0;
      cmd_q <= '0;
      data_q <= RPM_ZERO;
      rxd_q <= RPM_ZERO;
      rx_last_q <= 1'b0;
      rx_done_q <= 1'b0;
      np_out_q <= 1'b0;
      pad_q <= 1'b0;
      rd_status_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          write_q <= 1'b0;
          read_q <= 1'b0;
          if (h_write_in && h_addr_in == RPM_H_DATA_OFF) begin
            data_q <= h_wdata_in;
          end
          if (h_write_in && h_addr_in == RPM_H_CMD_OFF) begin
            cmd_q <= h_wdata_in[5:0];
            busy_q <= 1'b1;
            rx_done_q <= 1'b0;
            pad_q <= h_wdata_in[RPM_HCMD_PAD];
            if (h_wdata_in[RPM_HCMD_RECV]) begin
              state_q <= ST_POLL;
            end else if (h_wdata_in[RPM_HCMD_SEND]) begin
              state_q <= ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          // Data write always precedes its control write
          write_q <= 1'b1;
          addr_q <= RPM_TX_DWORD_OFF;
          wdata_q <= pad_q ? RPM_DUMMY : data_q;
          state_q <= ST_WCTRL;
        end
        ST_WCTRL: begin
          if (!(write_q && bus.wait_req)) begin
            write_q <= 1'b1;
            addr_q <= RPM_TX_CTRL_OFF;
            wdata_q <= {29'h0, cmd_q[RPM_HCMD_POSTED], cmd_q[RPM_HCMD_LAST],
                        cmd_q[RPM_HCMD_FIRST]};
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Hold the control write while the device stalls it
          if (!bus.wait_req) begin
            write_q <= 1'b0;
            busy_q <= 1'b0;
            if (cmd_q[RPM_HCMD_FIRST] && !cmd_q[RPM_HCMD_POSTED]) begin
              np_out_q <= 1'b1;
            end
            state_q <= ST_IDLE;
          end
        end
        ST_POLL: begin
          write_q <= 1'b0;
          read_q <= !read_q;
          addr_q <= RPM_RX_STATUS_OFF;
          if (bus.rvalid) begin
            // First pass waits for bit 0, later passes take the last flag
            if (!rd_status_q && bus.rdata[RPM_ST_FIRST]) begin
              rd_status_q <= 1'b1;
              rx_last_q <= 1'b0;
              read_q <= 1'b1;
              addr_q <= RPM_RX_DWORD_OFF;
              state_q <= ST_RDATA;
            end else if (rd_status_q) begin
              rx_last_q <= bus.rdata[RPM_ST_LAST];
              read_q <= 1'b1;
              addr_q <= RPM_RX_DWORD_OFF;
              state_q <= ST_RDATA;
            end
          end
        end
        ST_RDATA: begin
          read_q <= 1'b0;
          if (bus.rvalid) begin
            rxd_q <= bus.rdata;
            busy_q <= 1'b0;
            if (rx_last_q) begin
              rx_done_q <= 1'b1;
              rd_status_q <= 1'b0;
              np_out_q <= 1'b0;
            end
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      h_rdata_out <= RPM_ZERO;
    end else if (h_read_in && h_addr_in == RPM_H_STAT_OFF) begin
      h_rdata_out <= {28'h0000_000, np_out_q, rx_done_q, rx_last_q, busy_q};
    end else if (h_read_in && h_addr_in == RPM_H_RXD_OFF) begin
      h_rdata_out <= rxd_q;
    end else begin
      h_rdata_out <= RPM_ZERO;
    end
  end
endmodule : rpm_app

//--- verif/rpm_properties.sv
/* Checker for the register port between the two mailbox ends.
   Assumes the signals of one rpm_if instance on clock_in. */
`timescale 1ns/1ns
module rpm_properties
  import rpm_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic [RPM_AW-1:0] addr,
  input wire logic [RPM_DW-1:0] wdata,
  input wire logic write,
  input wire logic read,
  input wire logic [RPM_DW-1:0] rdata,
  input wire logic rvalid,
  input wire logic wait_req
);
  logic data_q;
  logic stat_q;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // A control write must pair with a fresh data write
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) data_q <= 1'b0;
    else if (write && !wait_req && addr == RPM_TX_DWORD_OFF) data_q <= 1'b1;
    else if (write && !wait_req && addr == RPM_TX_CTRL_OFF) data_q <= 1'b0;
  end
  // A dword read must follow a status read
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) stat_q <= 1'b0;
    else if (read && addr == RPM_RX_STATUS_OFF) stat_q <= 1'b1;
    else if (read && addr == RPM_RX_DWORD_OFF) stat_q <= 1'b0;
  end
  sequence s_answer;
    ##1 rvalid;
  endsequence
  sequence s_held;
    ##1 write && $stable(addr) && $stable(wdata);
  endsequence
  read_answer_a: assert property (read |-> s_answer)
    else $error("read without answer");
  answer_once_a: assert property (!read |=> !rvalid)
    else $error("answer without read");
  strobe_excl_a: assert property (!(write && read))
    else $error("both strobes high");
  wait_hold_a: assert property (write && wait_req |-> s_held)
    else $error("stalled write not held");
  wait_scope_a: assert property (wait_req |-> write && addr == RPM_TX_CTRL_OFF)
    else $error("stall outside control write");
  ctrl_code_a: assert property (write && addr == RPM_TX_CTRL_OFF |->
    wdata[31:3] == 29'h0 && wdata[1:0] != 2'h3)
    else $error("bad control value");
  push_pair_a: assert property (write && !wait_req && addr == RPM_TX_CTRL_OFF |-> data_q)
    else $error("push without data");
  status_fmt_a: assert property (read && addr == RPM_RX_STATUS_OFF |=>
    rdata[31:2] == 30'h0 && rdata[1:0] != 2'h3)
    else $error("bad status value");
  poll_first_a: assert property (read && addr == RPM_RX_DWORD_OFF |-> stat_q)
    else $error("dword read without status read");
  reset_quiet_a: assert property ($fell(sys_rst_in) |-> !write && !read && !rvalid)
    else $error("port busy after reset");
endmodule : rpm_properties

//--- verif/tb_pcie_root_port_tlp_mailbox.sv
/* Testbench joining the application and device ends of the mailbox.
   Assumes the host command and status layout of the application end. */
`timescale 1ns/1ns
module tb_pcie_root_port_tlp_mailbox
  import rpm_pkg::*;
();
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] h_addr = 4'h0;
  logic [RPM_DW-1:0] h_wdata = 32'h0;
  logic h_write = 1'b0;
  logic h_read = 1'b0;
  logic [RPM_DW-1:0] h_rdata;
  logic [RPM_DW-1:0] tx_data;
  logic tx_valid;
  logic tx_first;
  logic tx_last;
  logic tx_posted;
  logic tx_ready = 1'b1;
  logic [RPM_DW-1:0] rx_data = 32'h0;
  logic rx_valid = 1'b0;
  logic rx_first = 1'b0;
  logic rx_last = 1'b0;
  logic rx_ready;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_closed = 0;
  int n_sent = 0;
  logic [2:0] ctl_q[$];
  logic [34:0] txq[$];
  logic [RPM_DW-1:0] cpl[4] = '{32'h4a00_0001, 32'h0100_0004, 32'h0000_1700, 32'hffef_0010};
  rpm_if bus_if();
  rpm_app u_rpm_app (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .h_addr_in(h_addr),
    .h_wdata_in(h_wdata), .h_write_in(h_write), .h_read_in(h_read),
    .h_rdata_out(h_rdata), .bus(bus_if));
  rpm_device u_rpm_device (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .bus(bus_if),
    .tx_data_out(tx_data), .tx_valid_out(tx_valid), .tx_first_out(tx_first),
    .tx_last_out(tx_last), .tx_posted_out(tx_posted), .tx_ready_in(tx_ready),
    .rx_data_in(rx_data), .rx_valid_in(rx_valid), .rx_first_in(rx_first),
    .rx_last_in(rx_last), .rx_ready_out(rx_ready));
  rpm_properties u_rpm_properties (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .write(bus_if.write), .read(bus_if.read),
    .rdata(bus_if.rdata), .rvalid(bus_if.rvalid), .wait_req(bus_if.wait_req));
  initial begin
    forever #25 clock_in = ~clock_in;
  end
  // Monitor: a packet may leave only once its last dword was pushed
  always @(posedge clock_in) begin
    if (!sys_rst_in && tx_valid && n_closed == n_sent) begin
      n_mismatch++;
      $display("unexpected tx_valid: expected 0, seen 1");
    end
    if (!sys_rst_in && bus_if.write && !bus_if.wait_req && bus_if.addr == RPM_TX_CTRL_OFF) begin
      ctl_q.push_back(bus_if.wdata[2:0]);
      if (bus_if.wdata[RPM_CTL_LAST]) n_closed++;
    end
    if (!sys_rst_in && tx_valid && tx_ready) begin
      txq.push_back({tx_posted, tx_first, tx_last, tx_data});
      if (tx_last) n_sent++;
    end
  end
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [RPM_DW-1:0] exp,
                     input logic [RPM_DW-1:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk
  task automatic timed_out(input string what);
    $display("unexpected %s: expected done, seen timeout", what);
    n_mismatch++;
    test_done();
  endtask : timed_out
  task automatic h_wr(input logic [3:0] a, input logic [RPM_DW-1:0] d);
    @(posedge clock_in);
    h_addr <= a;
    h_wdata <= d;
    h_write <= 1'b1;
    @(posedge clock_in);
    h_write <= 1'b0;
  endtask : h_wr
  task automatic h_rd(input logic [3:0] a, output logic [RPM_DW-1:0] d);
    @(posedge clock_in);
    h_addr <= a;
    h_read <= 1'b1;
    @(posedge clock_in);
    h_read <= 1'b0;
    #1;
    d = h_rdata;
  endtask : h_rd
  // Busy is polled, since a stalled push may take any number of cycles
  task automatic cmd(input logic [RPM_DW-1:0] c);
    logic [RPM_DW-1:0] s;
    int i;
    h_wr(4'h0, c);
    for (i = 0; i < 40; i++) begin
      h_rd(4'h2, s);
      if (s[0] === 1'b0) break;
    end
    if (i == 40) timed_out("busy");
  endtask : cmd
  task automatic send(input logic [RPM_DW-1:0] d[4], input logic [RPM_DW-1:0] p,
                      input logic [RPM_DW-1:0] lp);
    h_wr(4'h1, d[0]);
    cmd(32'h03 | p);
    for (int k = 1; k < 4; k++) begin
      h_wr(4'h1, d[k]);
      cmd((k == 3 ? 32'h05 | lp : 32'h01) | p);
    end
  endtask : send
  task automatic tx_expect(input logic [RPM_DW-1:0] d[4], input logic p);
    logic [34:0] got;
    int k;
    for (k = 0; k < 200 && txq.size() < 4; k++) @(posedge clock_in);
    if (txq.size() < 4) timed_out("tx packet");
    for (k = 0; k < 4; k++) begin
      got = txq.pop_front();
      chk("tx data", d[k], got[31:0]);
      chk("tx flags", {29'h0, p, (k == 0), (k == 3)}, {29'h0, got[34:32]});
      chk("control code", {29'h0, p, (k == 3), (k == 0)}, {29'h0, ctl_q.pop_front()});
    end
  endtask : tx_expect
  task automatic rx_push(input logic [RPM_DW-1:0] d[4]);
    int t;
    @(posedge clock_in);
    for (int k = 0; k < 4; k++) begin
      rx_data <= d[k];
      rx_valid <= 1'b1;
      rx_first <= (k == 0);
      rx_last <= (k == 3);
      for (t = 0; t < 50; t++) begin
        @(posedge clock_in);
        if (rx_ready === 1'b1) break;
      end
      if (t == 50) timed_out("rx ready");
    end
    rx_valid <= 1'b0;
    rx_data <= ~d[3];
  endtask : rx_push
  task automatic test_np_send();
    // Last host data is not zero, so only the pad command can give the dummy dword
    send('{32'h0400_0001, 32'h0000_170f, 32'h0100_0010, 32'h5a5a_a5a5}, 32'h0, 32'h20);
    tx_expect('{32'h0400_0001, 32'h0000_170f, 32'h0100_0010, 32'h0}, 1'b0);
    $display("non-posted send done");
  endtask : test_np_send
  task automatic test_receive();
    logic [RPM_DW-1:0] s;
    rx_push(cpl);
    for (int k = 0; k < 4; k++) begin
      cmd(32'h10);
      h_rd(4'h2, s);
      chk("rx done", {31'h0, (k == 3)}, {31'h0, s[2]});
      chk("rx last", {31'h0, (k == 3)}, {31'h0, s[1]});
      chk("np outstanding", {31'h0, (k != 3)}, {31'h0, s[3]});
      h_rd(4'h3, s);
      chk("rx dword", cpl[k], s);
    end
    $display("completion receive done");
  endtask : test_receive
  // Three packets against a stopped sink: one dword out, eight queued, the tenth push stalls
  task automatic test_posted_stall();
    logic [RPM_DW-1:0] pk_a[4] = '{32'h4000_0001, 32'h0000_110f, 32'h0100_0010, 32'hffff_ffff};
    logic [RPM_DW-1:0] pk_b[4] = '{32'h4400_0001, 32'h0000_120f, 32'h0100_0014, 32'h0000_0001};
    logic [RPM_DW-1:0] pk_c[4] = '{32'h4400_0001, 32'h0000_130f, 32'h0100_0018, 32'h0000_0002};
    int t;
    @(posedge clock_in);
    tx_ready <= 1'b0;
    fork
      begin
        send(pk_a, 32'h08, 32'h0);
        send(pk_b, 32'h08, 32'h0);
        send(pk_c, 32'h08, 32'h0);
      end
      begin
        for (t = 0; t < 400 && bus_if.wait_req !== 1'b1; t++) @(posedge clock_in);
        chk("write stalled", 32'h1, {31'h0, bus_if.wait_req});
        repeat (5) @(posedge clock_in);
        #1;
        chk("stalled valid", 32'h1, {31'h0, tx_valid});
        chk("stalled dword", 32'h4000_0001, tx_data);
        @(posedge clock_in);
        tx_ready <= 1'b1;
      end
    join
    tx_expect(pk_a, 1'b1);
    tx_expect(pk_b, 1'b1);
    tx_expect(pk_c, 1'b1);
    $display("posted send with stall done");
  endtask : test_posted_stall
  task automatic test_reset();
    logic [RPM_DW-1:0] s;
    rx_push(cpl);
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    h_rd(4'h2, s);
    chk("status after reset", 32'h0, s);
    #1;
    chk("tx valid after reset", 32'h0, {31'h0, tx_valid});
    // A stale head left in the receive queue would come out first here
    rx_push('{32'h0a00_0000, 32'h0100_0004, 32'h0000_1100, 32'h5a00_0000});
    cmd(32'h10);
    h_rd(4'h3, s);
    chk("rx dword after reset", 32'h0a00_0000, s);
    $display("mid-run reset done");
  endtask : test_reset
  initial begin
    repeat (2) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    test_np_send();
    test_receive();
    test_posted_stall();
    test_reset();
    test_done();
  end
endmodule : tb_pcie_root_port_tlp_mailbox
